// file: verilog/smbcf_top.v
// Configuration and status register of the second two-wire port
// ==========================================================
// How it works
// - Enable bit activates port, watches both lines
// - Inhibit bit blocks target interrupts, controller kept
// - Hardware sets busy flag during transfers
// - Busy flag cleared on STOP or free timeout
// - Timing-extend bit selects normal or extended timing
// - Clock-low detection: timer reload while clock high
// - Split timer: only high byte held reload
// - Bus free after >10 rate periods both high
// - Rate source picks one of four overflows
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "smbcf_regs.vh"
module smbcf_top
(
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire serial_clock_line,
   input wire serial_data_line,
   input wire t0_ovf,
   input wire t5_ovf,
   input wire t2h_ovf,
   input wire t2l_ovf,
   input wire timer4_split,
   input wire target_event,
   input wire controller_event,
   output reg port_enable_bit,
   output reg data_timing_extend,
   output reg bit_rate_tick,
   output reg timer4_reload_high,
   output reg timer4_reload_low,
   output reg port_irq,
   output reg bus_free_pulse,
   output reg transfer_active_flag
);

   // Configuration fields
   reg target_interrupt_inhibit;
   reg clock_low_timeout_enable;
   reg bus_free_timeout_enable;
   reg [1:0] rate_source_select;

   // Bus slave state
   reg wr_pend_r;
   reg sel_cfg_r;

   // Line monitor state
   wire [1:0] lines_s;
   reg scl_d_r;
   reg sda_d_r;
   reg [3:0] free_cnt_r;
   reg [3:0] free_cnt_nxt;
   reg busy_nxt;
   reg rate_sel;

   wire scl_s;
   wire sda_s;
   wire take;
   wire addr_hit;
   wire start_seen;
   wire stop_seen;
   wire free_seen;
   wire [7:0] cfg_val;
   wire [7:0] wr_byte;

   // ==========================================================
   // Pin synchronisers
   smbcf_sync #(.W(2)) u_sync
   (
      .clk(hclk),
      .rst_n(hresetn),
      .ce(clk_en),
      .d({serial_clock_line, serial_data_line}),
      .q(lines_s)
   );

   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   // ==========================================================
   // Register image as software sees it
   assign cfg_val = {port_enable_bit, target_interrupt_inhibit,
                     transfer_active_flag, data_timing_extend,
                     clock_low_timeout_enable, bus_free_timeout_enable,
                     rate_source_select};

   // ==========================================================
   // AHB-Lite address phase decode
   assign take = hsel & htrans[1] & hready;
   assign addr_hit = (haddr[`SMBCF_ADDR_W-1:0] == `SMBCF_CFG_ADDR) &
                     (haddr[31:`SMBCF_ADDR_W] == 20'h00000) &
                     (hsize == 3'h2);
   assign wr_byte = hwdata[7:0] & `SMBCF_WR_MASK;

   // Address phase capture; write lands in the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         sel_cfg_r <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else if (clk_en)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready)
         begin
            wr_pend_r <= take & hwrite;
            sel_cfg_r <= take & addr_hit;
         end
      end
   end

   // Read data, forwarded from a write still in its data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (clk_en)
      begin
         if (take & ~hwrite & addr_hit)
         begin
            if (wr_pend_r & sel_cfg_r)
               hrdata <= {24'h000000, wr_byte[7:6], transfer_active_flag,
                          wr_byte[4:0]};
            else
               hrdata <= {24'h000000, cfg_val};
         end
         else if (take)
            hrdata <= 32'h00000000;
      end
   end

   // ==========================================================
   // Writable configuration fields
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         port_enable_bit <= 1'b0;
         target_interrupt_inhibit <= 1'b0;
         data_timing_extend <= 1'b0;
         clock_low_timeout_enable <= 1'b0;
         bus_free_timeout_enable <= 1'b0;
         rate_source_select <= 2'h0;
      end
      else if (clk_en & wr_pend_r & sel_cfg_r)
      begin
         // Busy bit position is skipped here
         port_enable_bit <= wr_byte[`SMBCF_EN_BIT];
         target_interrupt_inhibit <= wr_byte[`SMBCF_INH_BIT];
         data_timing_extend <= wr_byte[`SMBCF_EXT_BIT];
         clock_low_timeout_enable <= wr_byte[`SMBCF_TOE_BIT];
         bus_free_timeout_enable <= wr_byte[`SMBCF_FTE_BIT];
         rate_source_select <= wr_byte[`SMBCF_CS_HI:`SMBCF_CS_LO];
      end
   end

   // ==========================================================
   // Rate source multiplexer
   always @*
   begin
      case (rate_source_select)
         `SMBCF_CS_T0: rate_sel = t0_ovf;
         `SMBCF_CS_T5: rate_sel = t5_ovf;
         `SMBCF_CS_T2H: rate_sel = t2h_ovf;
         `SMBCF_CS_T2L: rate_sel = t2l_ovf;
         default: rate_sel = 1'b0;
      endcase
   end

   // ==========================================================
   // Line conditions seen on the synchronised levels
   assign start_seen = port_enable_bit & scl_s & scl_d_r &
                       sda_d_r & ~sda_s;
   assign stop_seen = port_enable_bit & scl_s & scl_d_r &
                      ~sda_d_r & sda_s;
   assign free_seen = port_enable_bit & bus_free_timeout_enable &
                      scl_s & sda_s & rate_sel &
                      (free_cnt_r == `SMBCF_FREE_PERIODS);

   // Free timeout counter: periods with both lines high
   always @*
   begin
      free_cnt_nxt = free_cnt_r;
      if (!port_enable_bit || !bus_free_timeout_enable || !scl_s || !sda_s)
         free_cnt_nxt = 4'h0;
      else if (rate_sel && free_cnt_r != `SMBCF_FREE_PERIODS)
         free_cnt_nxt = free_cnt_r + 4'h1;
   end

   // Busy flag: start sets, STOP or free timeout clears
   always @*
   begin
      busy_nxt = transfer_active_flag;
      if (!port_enable_bit)
         busy_nxt = 1'b0;
      else if (start_seen)
         busy_nxt = 1'b1;
      else if (stop_seen || free_seen)
         busy_nxt = 1'b0;
      else if (!scl_s || !sda_s)
         busy_nxt = 1'b1;
   end

   // ==========================================================
   // Line monitor registers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         free_cnt_r <= 4'h0;
         transfer_active_flag <= 1'b0;
         bus_free_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         free_cnt_r <= free_cnt_nxt;
         transfer_active_flag <= busy_nxt;
         bus_free_pulse <= free_seen;
      end
   end

   // ==========================================================
   // Timer steering, bit-rate tick and interrupt request
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         timer4_reload_high <= 1'b0;
         timer4_reload_low <= 1'b0;
         bit_rate_tick <= 1'b0;
         port_irq <= 1'b0;
      end
      else if (clk_en)
      begin
         // Reload while clock high, count while clock low
         timer4_reload_high <= port_enable_bit &
                               clock_low_timeout_enable & scl_s;
         timer4_reload_low <= port_enable_bit & clock_low_timeout_enable &
                              scl_s & ~timer4_split;
         bit_rate_tick <= port_enable_bit & rate_sel;
         // Target events are dropped while inhibited
         port_irq <= port_enable_bit & (controller_event |
                     (target_event & ~target_interrupt_inhibit));
      end
   end

endmodule

// file: verilog/smbcf_regs.vh
// Register map, field positions, reset values and counts for the port block
`ifndef SMBCF_REGS_VH
`define SMBCF_REGS_VH
// ==========================================================
// Register map
`define SMBCF_CFG_INDEX 12'h0C1
`define SMBCF_CFG_ADDR 12'h304
`define SMBCF_ADDR_W 12
// ==========================================================
// Field positions of the configuration register
`define SMBCF_EN_BIT 7
`define SMBCF_INH_BIT 6
`define SMBCF_BUSY_BIT 5
`define SMBCF_EXT_BIT 4
`define SMBCF_TOE_BIT 3
`define SMBCF_FTE_BIT 2
`define SMBCF_CS_HI 1
`define SMBCF_CS_LO 0
`define SMBCF_CFG_RESET 8'h00
`define SMBCF_WR_MASK 8'hDF
// ==========================================================
// Rate source encodings
`define SMBCF_CS_T0 2'h0
`define SMBCF_CS_T5 2'h1
`define SMBCF_CS_T2H 2'h2
`define SMBCF_CS_T2L 2'h3
// ==========================================================
// Timing counts
`define SMBCF_FREE_PERIODS 4'hA
`define SMBCF_TOUT_MS 25
`endif

// file: verilog/smbcf_sync.v
// Two-flop synchroniser for pin levels entering the system clock domain
`timescale 1ns/10ps
module smbcf_sync
#(
   parameter W = 2
)
(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   genvar i;
   // ==========================================================
   // One two-stage chain per bit, reset to idle-high bus level
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r[i] <= 1'b1;
               sync_r[i] <= 1'b1;
            end
            else if (ce)
            begin
               meta_r[i] <= d[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign q = sync_r;

endmodule

// file: tb/smbcf_line_model.sv
// Far bus party driving the two pulled-up port lines
`timescale 1ns/10ps
module smbcf_line_model
(
   output logic scl,
   output logic sda
);
   localparam int HALF = 400;
   // Lines rest high on their pull-ups
   initial
   begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Data falls with clock high, then clock goes low
   task start;
      #13 sda = 1'h0;
      #(2*HALF) scl = 1'h0;
   endtask
   // Clock rises, then data rises with clock high
   task stop;
      #HALF scl = 1'h1;
      #HALF sda = 1'h1;
   endtask
   // Data rises while clock low, so no STOP is seen
   task idle_up;
      #HALF sda = 1'h1;
      #HALF scl = 1'h1;
   endtask
   // Clock held at a level, data untouched
   task scl_lvl(input logic v);
      #HALF scl = v;
   endtask
endmodule

// file: tb/smbcf_assertions.sv
// Concurrent checks on the pins of the configuration block
`timescale 1ns/10ps
module smbcf_chk
(
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire serial_clock_line,
   input wire serial_data_line,
   input wire t0_ovf,
   input wire t5_ovf,
   input wire t2h_ovf,
   input wire t2l_ovf,
   input wire timer4_split,
   input wire target_event,
   input wire controller_event,
   input wire port_enable_bit,
   input wire bit_rate_tick,
   input wire timer4_reload_high,
   input wire timer4_reload_low,
   input wire port_irq,
   input wire bus_free_pulse,
   input wire transfer_active_flag
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // Line sequences
   sequence s_scl_low;
      !serial_clock_line [*6];
   endsequence
   sequence s_sda_low;
      (port_enable_bit && !serial_data_line) [*6];
   endsequence
   a_busy_line_low: assert property (s_sda_low |->
      transfer_active_flag)
      else $error("busy not set with data line low");
   a_reload_scl_low: assert property (s_scl_low |->
      !timer4_reload_high)
      else $error("reload held with clock line low");
   a_reload_enable: assert property (timer4_reload_high |->
      $past(port_enable_bit))
      else $error("reload without port enable");
   a_reload_split: assert property (timer4_reload_low |->
      !$past(timer4_split))
      else $error("low byte reload in split mode");
   a_tick_cause: assert property (bit_rate_tick |->
      $past(port_enable_bit && (t0_ovf|t5_ovf|t2h_ovf|t2l_ovf)))
      else $error("rate tick without overflow");
   a_irq_cause: assert property (port_irq |->
      $past(target_event|controller_event))
      else $error("interrupt without event");
   // A controller event at an edge with the clock enable and port enable high must raise the request
   a_irq_ctrl: assert property (clk_en && controller_event &&
      port_enable_bit |=> port_irq)
      else $error("controller interrupt lost");
   a_free_clears: assert property (bus_free_pulse |=>
      !transfer_active_flag)
      else $error("busy kept after free timeout");
   a_free_lines_high: assert property (bus_free_pulse |->
      $past(serial_clock_line && serial_data_line, 4))
      else $error("free timeout with a line low");
endmodule
bind smbcf_top smbcf_chk i_chk (.hclk, .hresetn, .clk_en, .serial_clock_line,
   .serial_data_line, .t0_ovf, .t5_ovf, .t2h_ovf, .t2l_ovf, .timer4_split,
   .target_event, .controller_event, .port_enable_bit, .bit_rate_tick,
   .timer4_reload_high, .timer4_reload_low, .port_irq, .bus_free_pulse,
   .transfer_active_flag);

// file: tb/testbench.sv
// Self-checking bench of the port configuration block
`timescale 1ns/10ps
`include "smbcf_regs.vh"
module testbench;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [3:0] ovf = 4'h0;
   logic split = 1'h0, tev = 1'h0, cev = 1'h0;
   logic hready, hresp, en, ext, tick, rl_h, rl_l, irq, freep, busy, scl, sda;
   logic [2:0] q;
   logic ce = 1'h1;
   int mismatches = 0;
   int n_checks = 0;
   localparam logic [31:0] CFG = {20'h0, `SMBCF_CFG_ADDR};
   smbcf_line_model i_line (.scl(scl), .sda(sda));
   smbcf_top i_dut (.hclk, .hresetn, .clk_en(ce), .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
      .hresp, .serial_clock_line(scl), .serial_data_line(sda),
      .t0_ovf(ovf[0]), .t5_ovf(ovf[1]), .t2h_ovf(ovf[2]), .t2l_ovf(ovf[3]),
      .timer4_split(split), .target_event(tev), .controller_event(cev),
      .port_enable_bit(en), .data_timing_extend(ext), .bit_rate_tick(tick),
      .timer4_reload_high(rl_h), .timer4_reload_low(rl_l), .port_irq(irq),
      .bus_free_pulse(freep), .transfer_active_flag(busy));
   // Clock of 100 ns
   always #50 hclk = ~hclk;
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         mismatches++;
      end
   endtask
   // Bounded wait for hready at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'h1 && n < 20);
      if (hready !== 1'h1)
      begin
         mismatches++;
         summarize;
      end
   endtask
   // One single word transfer, read data left in rd
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      chk("hresp", 32'h0, hresp);
   endtask
   // One-cycle strobe of {cev,tev,ovf}, returns {freep,irq,tick} after it
   task strobe(input logic [5:0] m, output logic [2:0] r);
      {cev, tev, ovf} <= m;
      @(posedge hclk);
      {cev, tev, ovf} <= 6'h0;
      #1 r = {freep, irq, tick};
      @(posedge hclk);
   endtask
   task wait_busy(input logic v);
      int n;
      n = 0;
      while (busy !== v && n < 40)
      begin
         @(posedge hclk);
         n++;
      end
      chk("busy", v, busy);
      // A wait that ran out ends the run
      if (busy !== v)
         summarize;
   endtask
   task t_regs;
      ahb(1'h0, CFG, 32'h0);
      chk("cfg reset", 32'h0, rd);
      ahb(1'h1, CFG, 32'hFF);
      ahb(1'h0, CFG, 32'h0);
      chk("cfg rw", 32'hDF, rd);
      chk("enable", 1'h1, en);
      chk("extend", 1'h1, ext);
      ahb(1'h1, CFG, 32'h0);
      ahb(1'h0, 32'h300, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("normal timing", 1'h0, ext);
   endtask
   task t_rate;
      for (int c = 0; c < 4; c++)
      begin
         ahb(1'h1, CFG, 32'h80 + c);
         for (int i = 0; i < 4; i++)
         begin
            strobe(6'h1 << i, q);
            chk("rate tick", (i == c), q[0]);
         end
      end
   endtask
   task t_busy;
      ahb(1'h1, CFG, 32'h84);
      i_line.start();
      wait_busy(1'h1);
      i_line.stop();
      wait_busy(1'h0);
      i_line.start();
      wait_busy(1'h1);
      i_line.idle_up();
      repeat (6) @(posedge hclk);
      repeat (10) strobe(6'h1, q);
      chk("busy ten periods", 1'h1, busy);
      chk("free early", 1'h0, q[2]);
      strobe(6'h1, q);
      chk("free pulse", 1'h1, q[2]);
      strobe(6'h1, q);
      wait_busy(1'h0);
      @(posedge hclk);
   endtask
   task t_reload;
      ahb(1'h1, CFG, 32'h88);
      repeat (6) @(posedge hclk);
      chk("reload high", 1'h1, rl_h);
      chk("reload low", 1'h1, rl_l);
      split <= 1'h1;
      repeat (2) @(posedge hclk);
      chk("split high", 1'h1, rl_h);
      chk("split low", 1'h0, rl_l);
      // Clock held low: the timeout timer is free to count
      i_line.scl_lvl(1'h0);
      repeat (6) @(posedge hclk);
      chk("clock low", 1'h0, rl_h);
      i_line.scl_lvl(1'h1);
      @(posedge hclk);
   endtask
   task t_irq;
      ahb(1'h1, CFG, 32'h80);
      strobe(6'h10, q);
      chk("target irq", 1'h1, q[1]);
      ahb(1'h1, CFG, 32'hC0);
      strobe(6'h10, q);
      chk("inhibited irq", 1'h0, q[1]);
      strobe(6'h20, q);
      chk("controller irq", 1'h1, q[1]);
      // Clock enable low freezes the interrupt register
      ce <= 1'h0;
      strobe(6'h20, q);
      chk("frozen irq", 1'h0, q[1]);
      ce <= 1'h1;
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      t_regs;
      t_rate;
      t_busy;
      t_reload;
      t_irq;
      summarize;
   end
endmodule
